// >>> hw/lc_pkg.sv
// package: constants, modes and bus carriers for the logic cell block
package lc_pkg;

	localparam int LC_CELLS = 4;
	localparam int LC_SRCS = 32;
	localparam int LC_LINES = 4;
	localparam int LC_GATES = 4;
	localparam int LC_SEL_W = 5;
	localparam int LC_GLS_W = 8;
	localparam int LC_GRP_W = 8;

	// byte offsets, per-cell registers repeat every stride
	localparam logic [7:0] LC_CELL_STRIDE = 8'h20;
	localparam logic [4:0] LC_OFF_CON = 5'h00;
	localparam logic [4:0] LC_OFF_SEL = 5'h04;
	localparam logic [4:0] LC_OFF_GLS0 = 5'h08;
	localparam logic [4:0] LC_OFF_GLS1 = 5'h0C;
	localparam logic [4:0] LC_OFF_GLS2 = 5'h10;
	localparam logic [4:0] LC_OFF_GLS3 = 5'h14;
	localparam logic [7:0] LC_OFF_SWBITS = 8'h80;
	localparam logic [7:0] LC_OFF_STATUS = 8'h84;

	// control register fields
	localparam int LC_CON_EN = 0;
	localparam int LC_CON_MODE = 1;
	localparam int LC_CON_POL = 4;
	localparam int LC_CON_GPOL = 5;
	localparam int LC_CON_PINEN = 9;
	localparam int LC_CON_OUT = 10;
	localparam int LC_CON_W = 10;

	// reset values
	localparam logic [9:0] LC_CON_RST = 10'h000;
	localparam logic [19:0] LC_SEL_RST = 20'h00000;
	localparam logic [7:0] LC_SW_RST = 8'h00;
	localparam logic [7:0] LC_GLS_POR = 8'h00;

	localparam logic [1:0] LC_RESP_OKAY = 2'h0;
	localparam logic [1:0] LC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		LC_M_AND_OR,
		LC_M_OR_XOR,
		LC_M_AND4,
		LC_M_SR,
		LC_M_DFF_SR,
		LC_M_JK_R,
		LC_M_DLATCH_SR,
		LC_M_DFF_R
	} lc_mode_type;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} lc_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lc_axi_rsp_type;

endpackage

// >>> hw/lc_gls_bank.sv
// gate-select storage for all cells, cleared only by power-on reset
`timescale 1ns/1ps
module lc_gls_bank import lc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic por_n_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic [1:0] cell_i,
	input wire logic [1:0] gate_i,
	input wire logic [7:0] data_i,
	output logic [LC_CELLS*LC_GATES*LC_GLS_W-1:0] gls_o
);

	typedef struct packed {
		logic [LC_CELLS*LC_GATES*LC_GLS_W-1:0] gls;
	} lc_gls_state_type;

	lc_gls_state_type st_r;
	lc_gls_state_type st_nxt;

	// one byte per gate, cell-major order
	always_comb begin
		st_nxt = st_r;
		if (wr_i) begin
			st_nxt.gls[{cell_i, gate_i, 3'b000} +: LC_GLS_W] = data_i;
		end
	end

	// system resets leave these bits alone; only power-on clears them
	always_ff @(posedge ref_clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			st_r <= '{gls: {LC_CELLS*LC_GATES{LC_GLS_POR}}};
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign gls_o = st_r.gls;

endmodule

// >>> hw/lc_func.sv
// one cell's input gates and its selectable logic function, no state
`timescale 1ns/1ps
module lc_func import lc_pkg::*; (
	input wire logic [LC_LINES-1:0] lines_i,
	input wire logic [LC_GATES*LC_GLS_W-1:0] gls_i,
	input wire logic [LC_GATES-1:0] gpol_i,
	input wire lc_mode_type mode_i,
	input wire logic q_i,
	input wire logic g1_prev_i,
	output logic g1_o,
	output logic res_o,
	output logic q_nxt_o
);

	logic [LC_GATES-1:0] g;
	logic rise;

	// each gate ORs the enabled true/inverted terms, then optional invert
	for (genvar k = 0; k < LC_GATES; k++) begin : gen_gate
		logic [LC_GLS_W-1:0] terms;
		assign terms = {lines_i[3], ~lines_i[3], lines_i[2], ~lines_i[2],
			lines_i[1], ~lines_i[1], lines_i[0], ~lines_i[0]};
		assign g[k] = (|(gls_i[k*LC_GLS_W +: LC_GLS_W] & terms)) ^ gpol_i[k];
	end

	assign g1_o = g[0];
	// storage clocks are sampled, so a gate pulse shorter than a cycle is lost
	assign rise = g[0] & ~g1_prev_i;

	always_comb begin
		res_o = 1'b0;
		q_nxt_o = q_i;
		case (mode_i)
			LC_M_AND_OR: res_o = (g[0] & g[1]) | (g[2] & g[3]);
			LC_M_OR_XOR: res_o = (g[0] | g[1]) ^ (g[2] | g[3]);
			LC_M_AND4: res_o = &g;
			LC_M_SR: begin
				// set wins when both are asserted
				if (g[0] | g[1]) begin
					q_nxt_o = 1'b1;
				end else if (g[2] | g[3]) begin
					q_nxt_o = 1'b0;
				end
				res_o = q_nxt_o;
			end
			LC_M_DFF_SR: begin
				if (g[3]) begin
					q_nxt_o = 1'b1;
				end else if (g[2]) begin
					q_nxt_o = 1'b0;
				end else if (rise) begin
					q_nxt_o = g[1];
				end
				res_o = q_nxt_o;
			end
			LC_M_JK_R: begin
				if (g[2]) begin
					q_nxt_o = 1'b0;
				end else if (rise) begin
					case ({g[1], g[3]})
						2'b10: q_nxt_o = 1'b1;
						2'b01: q_nxt_o = 1'b0;
						2'b11: q_nxt_o = ~q_i;
						default: q_nxt_o = q_i;
					endcase
				end
				res_o = q_nxt_o;
			end
			LC_M_DLATCH_SR: begin
				if (g[3]) begin
					q_nxt_o = 1'b1;
				end else if (g[2]) begin
					q_nxt_o = 1'b0;
				end else if (g[0]) begin
					q_nxt_o = g[1];
				end
				res_o = q_nxt_o;
			end
			LC_M_DFF_R: begin
				if (g[2] | g[3]) begin
					q_nxt_o = 1'b0;
				end else if (rise) begin
					q_nxt_o = g[1];
				end
				res_o = q_nxt_o;
			end
			default: res_o = 1'b0;
		endcase
	end

endmodule

// >>> hw/lc_top.sv
// four logic cells with source selection and an AXI4-Lite register slave
//
// Notes on behaviour
// - each cell picks four lines out of 32 sources and gates them down
// - eight functions; combinational ones are AND-OR, OR-XOR, AND, with output invert
// - storage functions: S-R, clocked D set/reset, clocked D reset, transparent D, J-K with reset
// - sources are pins, internal clocks, peripheral signals and software bits
// - cell result goes to peripherals and to a pin output
// - four identical cells, each with its own control and gate registers
`timescale 1ns/1ps
module lc_top import lc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic por_n_i,
	input wire logic ce_i,
	input wire logic [LC_GRP_W-1:0] pin_i,
	input wire logic [LC_GRP_W-1:0] int_clk_i,
	input wire logic [LC_GRP_W-1:0] periph_i,
	input wire lc_axi_req_type axi_req_i,
	output lc_axi_rsp_type axi_rsp_o,
	output logic [LC_CELLS-1:0] cell_out_o,
	output logic [LC_CELLS-1:0] cell_pin_o
);

	typedef struct packed {
		logic [LC_GRP_W-1:0] pin_s1;
		logic [LC_GRP_W-1:0] pin_s2;
		logic [LC_GRP_W-1:0] clk_s1;
		logic [LC_GRP_W-1:0] clk_s2;
		logic [LC_CELLS-1:0][LC_CON_W-1:0] con;
		logic [LC_CELLS-1:0][LC_LINES*LC_SEL_W-1:0] sel;
		logic [LC_GRP_W-1:0] sw;
		logic [LC_CELLS-1:0] q;
		logic [LC_CELLS-1:0] g1_prev;
		logic [LC_CELLS-1:0] out;
		logic [LC_CELLS-1:0] pin_out;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		lc_axi_rsp_type rsp;
	} lc_state_type;

	localparam lc_axi_rsp_type LC_RSP_RST = '{
		awready: 1'b1,
		wready: 1'b1,
		bvalid: 1'b0,
		bresp: LC_RESP_OKAY,
		arready: 1'b1,
		rvalid: 1'b0,
		rdata: 32'h00000000,
		rresp: LC_RESP_OKAY
	};

	localparam lc_state_type LC_ST_RST = '{
		pin_s1: LC_SW_RST,
		pin_s2: LC_SW_RST,
		clk_s1: LC_SW_RST,
		clk_s2: LC_SW_RST,
		con: {LC_CELLS{LC_CON_RST}},
		sel: {LC_CELLS{LC_SEL_RST}},
		sw: LC_SW_RST,
		q: 4'h0,
		g1_prev: 4'h0,
		out: 4'h0,
		pin_out: 4'h0,
		aw_have: 1'b0,
		aw_addr: 8'h00,
		w_have: 1'b0,
		wdata: 32'h00000000,
		wstrb: 4'h0,
		rsp: LC_RSP_RST
	};

	lc_state_type st_r;
	lc_state_type st_nxt;

	logic [LC_SRCS-1:0] src;
	logic [LC_CELLS*LC_GATES*LC_GLS_W-1:0] gls;
	logic [LC_CELLS-1:0] g1;
	logic [LC_CELLS-1:0] res;
	logic [LC_CELLS-1:0] q_nxt;
	logic gls_wr;
	logic [1:0] gls_cell;
	logic [1:0] gls_gate;
	logic [7:0] gls_data;

	// byte-lane merge of a write onto the old register contents
	function automatic logic [31:0] lc_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// source vector: only synchronised copies of pins and clocks are used
	assign src = {st_r.sw, periph_i, st_r.clk_s2, st_r.pin_s2};

	// one identical cell per index
	for (genvar c = 0; c < LC_CELLS; c++) begin : gen_cell
		logic [LC_LINES-1:0] lines;
		for (genvar l = 0; l < LC_LINES; l++) begin : gen_line
			assign lines[l] = src[st_r.sel[c][l*LC_SEL_W +: LC_SEL_W]];
		end
		lc_func u_func (
			.lines_i(lines),
			.gls_i(gls[c*LC_GATES*LC_GLS_W +: LC_GATES*LC_GLS_W]),
			.gpol_i(st_r.con[c][LC_CON_GPOL +: LC_GATES]),
			.mode_i(lc_mode_type'(st_r.con[c][LC_CON_MODE +: 3])),
			.q_i(st_r.q[c]),
			.g1_prev_i(st_r.g1_prev[c]),
			.g1_o(g1[c]),
			.res_o(res[c]),
			.q_nxt_o(q_nxt[c])
		);
	end

	lc_gls_bank u_gls (
		.ref_clk_i(ref_clk_i),
		.por_n_i(por_n_i),
		.ce_i(ce_i),
		.wr_i(gls_wr),
		.cell_i(gls_cell),
		.gate_i(gls_gate),
		.data_i(gls_data),
		.gls_o(gls)
	);

	// next-state: synchronisers, bus slave, cell storage and outputs
	always_comb begin
		logic [1:0] cw;
		logic [1:0] cr;
		logic [31:0] m;
		st_nxt = st_r;
		gls_wr = 1'b0;
		gls_cell = 2'h0;
		gls_gate = 2'h0;
		gls_data = 8'h00;
		cw = st_r.aw_addr[6:5];
		cr = axi_req_i.araddr[6:5];
		m = 32'h00000000;

		// pins and foreign clocks pass two flops before use
		st_nxt.pin_s1 = pin_i;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.clk_s1 = int_clk_i;
		st_nxt.clk_s2 = st_r.clk_s1;

		// write channel: address and data are caught in either order
		if (st_r.rsp.bvalid && axi_req_i.bready) begin
			st_nxt.rsp.bvalid = 1'b0;
		end
		if (axi_req_i.awvalid && st_r.rsp.awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = axi_req_i.awaddr;
			cw = axi_req_i.awaddr[6:5];
		end
		if (axi_req_i.wvalid && st_r.rsp.wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.wdata = axi_req_i.wdata;
			st_nxt.wstrb = axi_req_i.wstrb;
		end
		if (st_nxt.aw_have && st_nxt.w_have) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = LC_RESP_OKAY;
			if (st_nxt.aw_addr == LC_OFF_SWBITS) begin
				m = lc_merge({24'h000000, st_r.sw}, st_nxt.wdata, st_nxt.wstrb);
				st_nxt.sw = m[7:0];
			end else if (st_nxt.aw_addr == LC_OFF_STATUS) begin
				// read-only: the write is dropped but still acknowledged
				st_nxt.rsp.bresp = LC_RESP_OKAY;
			end else if (st_nxt.aw_addr[7]) begin
				st_nxt.rsp.bresp = LC_RESP_SLVERR;
			end else begin
				case (st_nxt.aw_addr[4:0])
					LC_OFF_CON: begin
						m = lc_merge({22'h0, st_r.con[cw]}, st_nxt.wdata, st_nxt.wstrb);
						st_nxt.con[cw] = m[LC_CON_W-1:0];
					end
					LC_OFF_SEL: begin
						m = lc_merge({12'h000, st_r.sel[cw]}, st_nxt.wdata, st_nxt.wstrb);
						st_nxt.sel[cw] = m[19:0];
					end
					LC_OFF_GLS0, LC_OFF_GLS1, LC_OFF_GLS2, LC_OFF_GLS3: begin
						// only the low byte lane carries gate bits
						gls_wr = st_nxt.wstrb[0];
						gls_cell = cw;
						gls_gate = 2'(st_nxt.aw_addr[4:2] - 3'h2);
						gls_data = st_nxt.wdata[7:0];
					end
					default: st_nxt.rsp.bresp = LC_RESP_SLVERR;
				endcase
			end
		end
		st_nxt.rsp.awready = !st_nxt.aw_have && !st_nxt.rsp.bvalid;
		st_nxt.rsp.wready = !st_nxt.w_have && !st_nxt.rsp.bvalid;

		// read channel: one read at a time, answered one cycle after capture
		if (st_r.rsp.rvalid && axi_req_i.rready) begin
			st_nxt.rsp.rvalid = 1'b0;
		end
		if (axi_req_i.arvalid && st_r.rsp.arready) begin
			st_nxt.rsp.rvalid = 1'b1;
			st_nxt.rsp.rresp = LC_RESP_OKAY;
			st_nxt.rsp.rdata = 32'h00000000;
			if (axi_req_i.araddr == LC_OFF_SWBITS) begin
				st_nxt.rsp.rdata[7:0] = st_r.sw;
			end else if (axi_req_i.araddr == LC_OFF_STATUS) begin
				st_nxt.rsp.rdata[LC_CELLS-1:0] = st_r.out;
			end else if (axi_req_i.araddr[7]) begin
				st_nxt.rsp.rresp = LC_RESP_SLVERR;
			end else begin
				case (axi_req_i.araddr[4:0])
					LC_OFF_CON: begin
						st_nxt.rsp.rdata[LC_CON_W-1:0] = st_r.con[cr];
						st_nxt.rsp.rdata[LC_CON_OUT] = st_r.out[cr];
					end
					LC_OFF_SEL: st_nxt.rsp.rdata[19:0] = st_r.sel[cr];
					LC_OFF_GLS0, LC_OFF_GLS1, LC_OFF_GLS2, LC_OFF_GLS3: begin
						st_nxt.rsp.rdata[7:0] =
							gls[{cr, 2'(axi_req_i.araddr[4:2] - 3'h2), 3'b000} +: 8];
					end
					default: st_nxt.rsp.rresp = LC_RESP_SLVERR;
				endcase
			end
		end
		st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

		// cells: a disabled cell holds its storage and drives zero
		for (int c = 0; c < LC_CELLS; c++) begin
			st_nxt.g1_prev[c] = g1[c];
			if (st_r.con[c][LC_CON_EN]) begin
				st_nxt.q[c] = q_nxt[c];
				st_nxt.out[c] = res[c] ^ st_r.con[c][LC_CON_POL];
			end else begin
				st_nxt.out[c] = 1'b0;
			end
			st_nxt.pin_out[c] = st_nxt.out[c] & st_r.con[c][LC_CON_PINEN];
		end
	end

	// all state frozen while the clock enable is low
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= LC_ST_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign axi_rsp_o = st_r.rsp;
	assign cell_out_o = st_r.out;
	assign cell_pin_o = st_r.pin_out;

endmodule

// >>> dv/lc_src_model.sv
// source side model: pins, internal clocks and peripheral signals
`timescale 1ns/1ps
module lc_src_model import lc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic [23:0] src_i,
	output logic [LC_GRP_W-1:0] pin_o,
	output logic [LC_GRP_W-1:0] int_clk_o,
	output logic [LC_GRP_W-1:0] periph_o
);
	// quiet sources until the bench starts moving them
	initial begin
		pin_o = 8'h00;
		int_clk_o = 8'h00;
		periph_o = 8'h00;
	end
	// sources move just after the edge, like on-chip logic
	always @(posedge ref_clk_i) begin
		pin_o <= src_i[7:0];
		int_clk_o <= src_i[15:8];
		periph_o <= src_i[23:16];
	end
endmodule

// >>> dv/lc_top_monitor.sv
// assertions on the logic cell ports: bus handshakes and cell outputs
`timescale 1ns/1ps
module lc_top_monitor import lc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire lc_axi_req_type axi_req_i,
	input wire lc_axi_rsp_type axi_rsp_o,
	input wire logic [LC_CELLS-1:0] cell_out_o,
	input wire logic [LC_CELLS-1:0] cell_pin_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// address and data taken at one edge, as the bench offers them
	sequence s_aw_w;
		axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
	endsequence
	sequence s_ar;
		axi_req_i.arvalid && axi_rsp_o.arready;
	endsequence
	// holes: high half outside the two shared words, last two cell slots
	sequence s_ar_hole;
		s_ar ##0 (axi_req_i.araddr[7] ? (axi_req_i.araddr != LC_OFF_SWBITS &&
			axi_req_i.araddr != LC_OFF_STATUS) : axi_req_i.araddr[4:3] == 2'b11);
	endsequence
	property p_wr_ans; s_aw_w |=> axi_rsp_o.bvalid; endproperty
	property p_rd_ans; s_ar |=> axi_rsp_o.rvalid; endproperty
	property p_b_hold;
		axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
	endproperty
	property p_b_done; axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid; endproperty
	property p_r_hold;
		axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata);
	endproperty
	property p_ar_block; axi_rsp_o.rvalid |-> !axi_rsp_o.arready; endproperty
	property p_rd_err;
		s_ar_hole |=> axi_rsp_o.rresp == LC_RESP_SLVERR && axi_rsp_o.rdata == 32'h0;
	endproperty
	property p_pin; (cell_pin_o & ~cell_out_o) == 4'h0; endproperty
	property p_rst_out; $rose(reset_n_i) |-> cell_out_o == 4'h0; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_b_done: assert property (p_b_done) else $error("write answer repeated");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	a_ar_block: assert property (p_ar_block) else $error("read overlap");
	a_rd_err: assert property (p_rd_err) else $error("hole not refused");
	a_pin: assert property (p_pin) else $error("pin without result");
	a_rst_out: assert property (p_rst_out) else $error("output after reset");
endmodule

bind lc_top lc_top_monitor u_mon (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .cell_out_o(cell_out_o),
	.cell_pin_o(cell_pin_o));

// >>> dv/testbench.sv
// self-checking bench: registers over AXI4-Lite, gating and combinational functions of all cells, storage functions of cell 0
`timescale 1ns/1ps
module testbench import lc_pkg::*;;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic por_n_i = 1'b0;
	logic [23:0] src = 24'h0;
	lc_axi_req_type req = '0;
	lc_axi_rsp_type rsp;
	logic [7:0] pin, ick, per;
	logic [3:0] cout, cpin;
	logic [1:0] resp;
	logic [31:0] rd;
	logic [31:0] st;
	int fail_count = 0;
	int num_checks = 0;
	int sel_m [4][4];
	int gls_m [4][4];
	int con_m [4];
	int sw_m;
	int sv;
	logic ce = 1'b1;
	logic qm;
	logic g1m;

	always #12.5 ref_clk_i = ~ref_clk_i;

	lc_src_model u_src (.ref_clk_i(ref_clk_i), .src_i(src), .pin_o(pin), .int_clk_o(ick),
		.periph_o(per));
	// clock enable driven by the bench so freezing can be checked
	lc_top u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i), .ce_i(ce),
		.pin_i(pin), .int_clk_i(ick), .periph_i(per), .axi_req_i(req), .axi_rsp_o(rsp),
		.cell_out_o(cout), .cell_pin_o(cpin));

	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one bus transfer; conditions read mid-cycle, acted on at the next edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic at, wt, art, dn;
		@(posedge ref_clk_i);
		if (w) begin
			req.awaddr <= a;
			req.wdata <= d;
			req.wstrb <= 4'hF;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
			req.bready <= 1'b1;
		end else begin
			req.araddr <= a;
			req.arvalid <= 1'b1;
			req.rready <= 1'b1;
		end
		for (int n = 0; n < 40; n++) begin
			@(negedge ref_clk_i);
			at = req.awvalid & rsp.awready;
			wt = req.wvalid & rsp.wready;
			art = req.arvalid & rsp.arready;
			dn = w ? rsp.bvalid : rsp.rvalid;
			resp = w ? rsp.bresp : rsp.rresp;
			rd = rsp.rdata;
			@(posedge ref_clk_i);
			if (at) req.awvalid <= 1'b0;
			if (wt) req.wvalid <= 1'b0;
			if (art) req.arvalid <= 1'b0;
			if (dn) begin
				req.bready <= 1'b0;
				req.rready <= 1'b0;
				return;
			end
		end
		fail_count++;
		tally_and_finish();
	endtask

	// expected result of cell c from its model registers and the sources
	function automatic logic exp_out(int c);
		logic [31:0] v;
		logic [3:0] g;
		logic r;
		logic o;
		v = {sw_m[7:0], src};
		// a gate is the OR of its enabled terms, then its own invert
		for (int k = 0; k < 4; k++) begin
			o = 1'b0;
			for (int j = 0; j < 4; j++) begin
				o |= (gls_m[c][k][2*j+1] & v[sel_m[c][j]]) | (gls_m[c][k][2*j] & ~v[sel_m[c][j]]);
			end
			g[k] = o ^ con_m[c][5 + k];
		end
		case ((con_m[c] >> 1) & 7)
			0: r = (g[0] & g[1]) | (g[2] & g[3]);
			1: r = (g[0] | g[1]) ^ (g[2] | g[3]);
			default: r = &g;
		endcase
		return (r ^ con_m[c][4]) & con_m[c][0];
	endfunction

	// storage functions, one settled input change per call
	function automatic logic st_next(int md, logic [3:0] g, logic g1_old, logic q);
		logic rise;
		rise = g[0] & ~g1_old;
		case (md)
			3: return (g[0] | g[1]) ? 1'b1 : ((g[2] | g[3]) ? 1'b0 : q);
			4: return g[3] ? 1'b1 : (g[2] ? 1'b0 : (rise ? g[1] : q));
			5: return g[2] ? 1'b0 : (!rise ? q : (g[1] ^ g[3] ? g[1] : (g[1] ? ~q : q)));
			6: return g[3] ? 1'b1 : (g[2] ? 1'b0 : (g[0] ? g[1] : q));
			default: return (g[2] | g[3]) ? 1'b0 : (rise ? g[1] : q);
		endcase
	endfunction

	initial begin
		void'($urandom(32'h4CD7));
		repeat (12) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		por_n_i <= 1'b1;
		xfer(0, 8'h20, 32'h0);
		chk("control reset", 32'h0, rd);
		xfer(0, 8'h18, 32'h0);
		chk("hole read resp", LC_RESP_SLVERR, resp);
		xfer(1, 8'h3C, 32'h1);
		chk("hole write resp", LC_RESP_SLVERR, resp);
		// gate bytes must ride through a system reset
		for (int c = 0; c < 4; c++) xfer(1, 8'(c * 32 + 20), 32'hA5 ^ c);
		@(posedge ref_clk_i);
		reset_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			xfer(0, 8'(c * 32 + 20), 32'h0);
			chk("gate byte kept", 32'hA5 ^ c, rd);
		end
		// random set-ups, every cell watched on every vector
		for (int t = 0; t < 24; t++) begin
			int c;
			c = t % 4;
			sw_m = $urandom & 255;
			xfer(1, LC_OFF_SWBITS, sw_m);
			chk("write resp", LC_RESP_OKAY, resp);
			sv = 0;
			for (int j = 0; j < 4; j++) begin
				sel_m[c][j] = $urandom % 32;
				sv |= sel_m[c][j] << (5 * j);
			end
			xfer(1, 8'(c * 32 + 4), sv);
			for (int k = 0; k < 4; k++) begin
				gls_m[c][k] = $urandom & 255;
				xfer(1, 8'(c * 32 + 8 + 4 * k), gls_m[c][k]);
			end
			con_m[c] = 1 | (($urandom % 3) << 1) | ($urandom & 32'h3F0);
			xfer(1, 8'(c * 32), con_m[c]);
			for (int v = 0; v < 6; v++) begin
				@(posedge ref_clk_i);
				src <= 24'($urandom);
				repeat (6) @(posedge ref_clk_i);
				@(negedge ref_clk_i);
				for (int q = 0; q < 4; q++) begin
					chk("cell out", exp_out(q), cout[q]);
					chk("cell pin", exp_out(q) & con_m[q][9], cpin[q]);
				end
			end
			for (int q = 0; q < 4; q++) st[q] = exp_out(q);
			xfer(0, LC_OFF_STATUS, 32'h0);
			chk("status", {28'h0, st[3:0]}, rd);
		end
		// clock enable low: new sources must not reach the outputs until it returns
		for (int q = 0; q < 4; q++) st[q] = exp_out(q);
		@(posedge ref_clk_i);
		ce <= 1'b0;
		src <= 24'($urandom);
		repeat (6) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("frozen out", {28'h0, st[3:0]}, {28'h0, cout});
		@(posedge ref_clk_i);
		ce <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		for (int q = 0; q < 4; q++) chk("thawed out", exp_out(q), cout[q]);
		// storage functions on cell 0, gate k fed by peripheral bit k alone
		xfer(1, 8'h00, 32'h0);
		xfer(1, 8'h04, 16 | (17 << 5) | (18 << 10) | (19 << 15));
		for (int k = 0; k < 4; k++) xfer(1, 8'(8 + 4 * k), 32'h2 << (2 * k));
		qm = 1'b0;
		g1m = src[16];
		for (int md = 3; md < 8; md++) begin
			xfer(1, 8'h00, 32'(1 | (md << 1)));
			qm = st_next(md, src[19:16], g1m, qm);
			for (int s = 0; s < 8; s++) begin
				@(posedge ref_clk_i);
				src <= 24'($urandom);
				repeat (6) @(posedge ref_clk_i);
				@(negedge ref_clk_i);
				qm = st_next(md, src[19:16], g1m, qm);
				g1m = src[16];
				chk("storage out", qm, cout[0]);
			end
		end
		tally_and_finish();
	end
endmodule
